//--- shared/sacb_pkg.sv
// Package: register map, field layout, reset values and timing for the bank
package sacb_pkg;

  // ----------------------------------------------------------------------
  // Register indices (word addresses on the plain register port)
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_MON2     = 4'h0;
  localparam logic [3:0] ADDR_BRK_DLY  = 4'h1;
  localparam logic [3:0] ADDR_ZSP_RNG  = 4'h2;
  localparam logic [3:0] ADDR_LOG_CLR  = 4'h3;
  localparam logic [3:0] ADDR_ENC_OUT  = 4'h4;
  localparam logic [3:0] ADDR_STATION  = 4'h5;
  localparam logic [3:0] ADDR_COMM_SEL = 4'h6;
  localparam logic [3:0] ADDR_FUNC_C1  = 4'h7;
  localparam logic [3:0] ADDR_STATUS   = 4'h8;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h9;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hA;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_MON2     = 16'h0001;
  localparam logic [15:0] RST_BRK_DLY  = 16'h0064;
  localparam logic [15:0] RST_ZSP_RNG  = 16'h0032;
  localparam logic [15:0] RST_ZERO     = 16'h0000;

  // ----------------------------------------------------------------------
  // Ranges and field positions
  // ----------------------------------------------------------------------
  localparam logic [15:0] MAX_BRK_DLY  = 16'h03E8;  // 1000 ms
  localparam logic [15:0] MAX_ZSP_RNG  = 16'h2710;  // 10000 r/min
  localparam logic [15:0] ZSP_HYST     = 16'h0014;  // 20 r/min
  localparam logic [4:0]  MAX_STATION  = 5'h1F;
  localparam int          BIT_RESTART  = 0;
  localparam int          BIT_WIRE4    = 4;
  localparam int          BIT_LOG_CLR  = 0;

  // Interrupt bits
  localparam int IRQ_ALM_ONE = 0;
  localparam int IRQ_ALM_TWO = 1;
  localparam int IRQ_ZSP     = 2;
  localparam int IRQ_BASEOFF = 3;
  localparam int IRQ_W       = 4;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ      = 40_000_000;
  localparam int MS_PER_SEC  = 1000;
  localparam int CYC_PER_MS  = CLK_HZ / MS_PER_SEC;

  // Brake sequence states, Gray along the path
  typedef enum logic [1:0] {
    BRK_RUN  = 2'b00,
    BRK_WAIT = 2'b01,
    BRK_OFF  = 2'b11
  } sacb_brk_t;

  // Serial frame header from the receiver
  typedef struct packed {
    logic       valid;
    logic [4:0] station;
  } sacb_frame_t;

endpackage : sacb_pkg

//--- core/sacb_bank.sv
// Servo auxiliary configuration bank with brake timer and zero-speed flag
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Second monitor uses first table, default 0001h
// - Brake delay before base off, 0-1000ms
// - Zero-speed range 0-10000, default 50
// - Zero-speed detection has 20 r/min hysteresis
// - Log clear valid erases history at power-on
// - Log clear field returns to zero after erase
// - Station id 0-31, answer only own frames
// - Comm select picks interface, default 0000h
// - Encoder pulse select sets direction, config
// - Cable field: 0 two-wire, 1 four-wire
// - Cable mismatch raises encoder alarm one/two
module sacb_bank
  import sacb_pkg::*;
#(
  parameter int MS_CYCLES = CYC_PER_MS
)(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  // Power-on and drive inputs (pins, synchronised here)
  input  wire logic        power_on_i,
  input  wire logic        servo_off_i,
  input  wire logic        cable_four_wire_i,
  input  wire logic        power_dip_i,
  input  wire logic [15:0] speed_mag_i,
  input  wire sacb_frame_t frame_i,
  // Outputs
  output logic [15:0]      second_monitor_output_o,
  output logic             brake_interlock_o,
  output logic             base_drive_off_o,
  output logic             zero_speed_flag_o,
  output logic             history_erase_o,
  output logic             encoder_alarm_one_o,
  output logic             encoder_alarm_two_o,
  output logic             auto_restart_o,
  output logic [15:0]      encoder_pulse_cfg_o,
  output logic [15:0]      comm_cfg_o,
  output logic             frame_accept_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [3:0]  sync1;
  logic [3:0]  sync2;
  logic [15:0] spd1;
  logic [15:0] spd2;
  sacb_frame_t frm1;
  sacb_frame_t frm2;
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      spd1  <= 16'h0000;
      spd2  <= 16'h0000;
      frm1  <= '0;
      frm2  <= '0;
    end
    else
    begin
      sync1 <= {power_on_i, servo_off_i, cable_four_wire_i, power_dip_i};
      sync2 <= sync1;
      spd1  <= speed_mag_i;
      spd2  <= spd1;
      frm1  <= frame_i;
      frm2  <= frm1;
    end
  end
  logic pwr_s;
  logic soff_s;
  logic cable4_s;
  logic dip_s;
  assign pwr_s    = sync2[3];
  assign soff_s   = sync2[2];
  assign cable4_s = sync2[1];
  assign dip_s    = sync2[0];

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [15:0] mon2;
  logic [15:0] brk_dly;
  logic [15:0] zsp_rng;
  logic [15:0] log_clr;
  logic [15:0] enc_out;
  logic [15:0] station;
  logic [15:0] comm_sel;
  logic [15:0] func_c1;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic        pwr_d;
  logic        pwr_rise;
  logic        erase_done;
  logic [IRQ_W-1:0] irq_evt;

  assign pwr_rise = pwr_s & ~pwr_d;

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mon2     <= RST_MON2;
      brk_dly  <= RST_BRK_DLY;
      zsp_rng  <= RST_ZSP_RNG;
      enc_out  <= RST_ZERO;
      station  <= RST_ZERO;
      comm_sel <= RST_ZERO;
      func_c1  <= RST_ZERO;
      irq_mask <= '0;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        ADDR_MON2:     mon2 <= reg_wdata_i;
        ADDR_BRK_DLY:  brk_dly <= (reg_wdata_i > MAX_BRK_DLY) ?
                                  MAX_BRK_DLY : reg_wdata_i;
        ADDR_ZSP_RNG:  zsp_rng <= (reg_wdata_i > MAX_ZSP_RNG) ?
                                  MAX_ZSP_RNG : reg_wdata_i;
        ADDR_ENC_OUT:  enc_out <= reg_wdata_i;
        ADDR_STATION:  station <= {11'h000,
                                   reg_wdata_i[4:0] & MAX_STATION};
        ADDR_COMM_SEL: comm_sel <= reg_wdata_i;
        ADDR_FUNC_C1:  func_c1 <= reg_wdata_i;
        ADDR_IRQ_MASK: irq_mask <= reg_wdata_i[IRQ_W-1:0];
        default:       mon2 <= mon2;
      endcase
    end
  end

  // Log clear: software arms it, erase at power-on returns it to zero
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      log_clr    <= RST_ZERO;
      pwr_d      <= 1'b0;
      erase_done <= 1'b0;
    end
    else
    begin
      pwr_d      <= pwr_s;
      erase_done <= pwr_rise & log_clr[BIT_LOG_CLR];
      if (erase_done)
        log_clr <= RST_ZERO;
      else if (reg_wr_i && reg_addr_i == ADDR_LOG_CLR)
        log_clr <= {15'h0000, reg_wdata_i[BIT_LOG_CLR]};
    end
  end

  // ----------------------------------------------------------------------
  // Power-on latched settings
  // ----------------------------------------------------------------------
  // Changing these while running has no effect until the next power-on
  logic [15:0] enc_out_act;
  logic [15:0] comm_act;
  logic [4:0]  station_act;
  logic        wire4_act;
  logic        restart_act;
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      enc_out_act <= RST_ZERO;
      comm_act    <= RST_ZERO;
      station_act <= 5'h00;
      wire4_act   <= 1'b0;
      restart_act <= 1'b0;
    end
    else if (pwr_rise)
    begin
      enc_out_act <= enc_out;
      comm_act    <= comm_sel;
      station_act <= station[4:0];
      wire4_act   <= func_c1[BIT_WIRE4];
      restart_act <= func_c1[BIT_RESTART];
    end
  end

  // ----------------------------------------------------------------------
  // Brake sequence
  // ----------------------------------------------------------------------
  sacb_brk_t   brk_st;
  logic [15:0] ms_left;
  logic [31:0] ms_div;
  logic        ms_tick;
  assign ms_tick = (ms_div == 32'(MS_CYCLES - 1));
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      ms_div <= 32'h0000_0000;
    else if (brk_st != BRK_WAIT || ms_tick)
      ms_div <= 32'h0000_0000;
    else
      ms_div <= ms_div + 32'h0000_0001;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      brk_st  <= BRK_OFF;
      ms_left <= 16'h0000;
    end
    else
    begin
      case (brk_st)
        BRK_RUN:
          if (soff_s)
          begin
            brk_st  <= (brk_dly == 16'h0000) ? BRK_OFF : BRK_WAIT;
            ms_left <= brk_dly;
          end
        BRK_WAIT:
          if (!soff_s)
            brk_st <= BRK_RUN;
          else if (ms_tick)
          begin
            ms_left <= ms_left - 16'h0001;
            if (ms_left == 16'h0001)
              brk_st <= BRK_OFF;
          end
        BRK_OFF:
          if (!soff_s)
            brk_st <= BRK_RUN;
        default: brk_st <= BRK_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Zero-speed detection
  // ----------------------------------------------------------------------
  logic [16:0] zsp_hi;
  logic        zsp_flag;
  assign zsp_hi = {1'b0, zsp_rng} + {1'b0, ZSP_HYST};
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      zsp_flag <= 1'b1;
    else if ({1'b0, spd2} > zsp_hi)
      zsp_flag <= 1'b0;
    else if (spd2 <= zsp_rng)
      zsp_flag <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // Outputs, alarms and frame filter
  // ----------------------------------------------------------------------
  logic zsp_d;
  logic base_d;
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      second_monitor_output_o <= RST_MON2;
      brake_interlock_o       <= 1'b1;
      base_drive_off_o        <= 1'b1;
      zero_speed_flag_o       <= 1'b1;
      history_erase_o         <= 1'b0;
      encoder_alarm_one_o     <= 1'b0;
      encoder_alarm_two_o     <= 1'b0;
      auto_restart_o          <= 1'b0;
      encoder_pulse_cfg_o     <= RST_ZERO;
      comm_cfg_o              <= RST_ZERO;
      frame_accept_o          <= 1'b0;
      zsp_d                   <= 1'b1;
      base_d                  <= 1'b1;
    end
    else
    begin
      second_monitor_output_o <= mon2;
      brake_interlock_o       <= (brk_st != BRK_RUN);
      base_drive_off_o        <= (brk_st == BRK_OFF);
      zero_speed_flag_o       <= zsp_flag;
      history_erase_o         <= erase_done;
      encoder_alarm_one_o     <= wire4_act & ~cable4_s;
      encoder_alarm_two_o     <= ~wire4_act & cable4_s;
      auto_restart_o          <= restart_act & dip_s;
      encoder_pulse_cfg_o     <= enc_out_act;
      comm_cfg_o              <= comm_act;
      frame_accept_o          <= frm2.valid &&
                                 frm2.station == station_act;
      zsp_d                   <= zsp_flag;
      base_d                  <= (brk_st == BRK_OFF);
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, write one to clear; set wins over clear
  // ----------------------------------------------------------------------
  assign irq_evt[IRQ_ALM_ONE] = wire4_act & ~cable4_s & ~encoder_alarm_one_o;
  assign irq_evt[IRQ_ALM_TWO] = ~wire4_act & cable4_s & ~encoder_alarm_two_o;
  assign irq_evt[IRQ_ZSP]     = zsp_flag & ~zsp_d;
  assign irq_evt[IRQ_BASEOFF] = (brk_st == BRK_OFF) & ~base_d;
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      irq_stat <= '0;
    else if (reg_wr_i && reg_addr_i == ADDR_IRQ_STAT)
      irq_stat <= (irq_stat & ~reg_wdata_i[IRQ_W-1:0]) | irq_evt;
    else
      irq_stat <= irq_stat | irq_evt;
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |((irq_stat | irq_evt) & irq_mask);
  end

  // ----------------------------------------------------------------------
  // Read port, data one cycle after the strobe; unmapped reads as zero
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        ADDR_MON2:     reg_rdata_o <= mon2;
        ADDR_BRK_DLY:  reg_rdata_o <= brk_dly;
        ADDR_ZSP_RNG:  reg_rdata_o <= zsp_rng;
        ADDR_LOG_CLR:  reg_rdata_o <= log_clr;
        ADDR_ENC_OUT:  reg_rdata_o <= enc_out;
        ADDR_STATION:  reg_rdata_o <= station;
        ADDR_COMM_SEL: reg_rdata_o <= comm_sel;
        ADDR_FUNC_C1:  reg_rdata_o <= func_c1;
        ADDR_STATUS:   reg_rdata_o <= {10'h000, brk_st, zsp_flag,
                                       wire4_act, encoder_alarm_two_o,
                                       encoder_alarm_one_o};
        ADDR_IRQ_STAT: reg_rdata_o <= {12'h000, irq_stat};
        ADDR_IRQ_MASK: reg_rdata_o <= {12'h000, irq_mask};
        default:       reg_rdata_o <= 16'h0000;
      endcase
    end
    else
      reg_rdata_o <= 16'h0000;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_off_enter;
    brk_st == BRK_RUN && soff_s && brk_dly != 16'h0000;
  endsequence
  sequence s_off_still;
    soff_s;
  endsequence

  brake_first_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    base_drive_off_o |-> brake_interlock_o)
    else $error("base off without brake interlock");
  brake_wait_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    s_off_enter ##1 s_off_still |-> brk_st == BRK_WAIT)
    else $error("brake delay skipped");
  zsp_set_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    spd2 <= zsp_rng |=> zsp_flag)
    else $error("zero speed flag not set in range");
  zsp_hyst_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    zsp_flag && {1'b0, spd2} <= zsp_hi |=> zsp_flag)
    else $error("zero speed flag dropped inside band");
  log_clear_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    erase_done |=> log_clr == 16'h0000 ##1 history_erase_o == 1'b0)
    else $error("log clear not returned to zero");
  erase_cause_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    history_erase_o |-> $past(log_clr[BIT_LOG_CLR], 2))
    else $error("erase without armed clear");
  station_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !pwr_rise |=> $stable(station_act))
    else $error("station changed while running");
  alarm_pair_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !(encoder_alarm_one_o && encoder_alarm_two_o))
    else $error("both encoder alarms at once");

endmodule : sacb_bank
`default_nettype wire

//--- test/sacb_motor_model.sv
// Motor, encoder cable and brake model at the amplifier pins
`timescale 1ns/1ps
`default_nettype none
module sacb_motor_model (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  // Amplifier side
  input  wire logic        base_drive_off_i,
  input  wire logic        brake_interlock_i,
  // Bench control of the load
  input  wire logic [15:0] speed_cmd_i,
  input  wire logic        four_wire_cable_i,
  // Sensed by the amplifier
  output logic      [15:0] speed_mag_o,
  output logic             cable_four_wire_o
);
  // Held or unpowered shaft reads standstill at once; a real one
  // coasts down, which only stretches the zero-speed delay
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      speed_mag_o <= 16'h0000;
    else if (base_drive_off_i || brake_interlock_i)
      speed_mag_o <= 16'h0000;
    else
      speed_mag_o <= speed_cmd_i;
  end
  // Cable kind that the fitted encoder presents
  assign cable_four_wire_o = four_wire_cable_i;
endmodule : sacb_motor_model
`default_nettype wire

//--- test/test_servo_aux_config_bank.sv
// Self-checking bench for the servo auxiliary configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_servo_aux_config_bank
  import sacb_pkg::*;
();
  localparam int MS = 4;
  logic        core_clk_i  = 1'b0;
  logic        sys_rst_i   = 1'b1;
  logic [3:0]  reg_addr_i  = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic        power_on_i  = 1'b0;
  logic        servo_off_i = 1'b0;
  logic        power_dip_i = 1'b0;
  logic        four_wire   = 1'b0;
  logic [15:0] speed_cmd   = 16'h0000;
  sacb_frame_t frame_i     = '0;
  logic [15:0] rdata, mon2, spd, enc_cfg, comm_cfg;
  logic        cable, brk, base_off, zero_speed_range, erase, alm1, alm2;
  logic        restart, accept, irq;
  logic [8:0]  flg;
  int          bad_count = 0;
  int          total_checks = 0;

  assign flg = {irq, accept, restart, alm2, alm1, erase, zero_speed_range, base_off, brk};
  always #12.5 core_clk_i = ~core_clk_i;

  sacb_bank #(.MS_CYCLES(MS)) i_sacb_bank (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
    .power_on_i(power_on_i), .servo_off_i(servo_off_i),
    .cable_four_wire_i(cable), .power_dip_i(power_dip_i),
    .speed_mag_i(spd), .frame_i(frame_i),
    .second_monitor_output_o(mon2), .brake_interlock_o(brk),
    .base_drive_off_o(base_off), .zero_speed_flag_o(zero_speed_range),
    .history_erase_o(erase), .encoder_alarm_one_o(alm1),
    .encoder_alarm_two_o(alm2), .auto_restart_o(restart),
    .encoder_pulse_cfg_o(enc_cfg), .comm_cfg_o(comm_cfg),
    .frame_accept_o(accept), .irq_o(irq));

  sacb_motor_model i_sacb_motor_model (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .base_drive_off_i(base_off), .brake_interlock_i(brk),
    .speed_cmd_i(speed_cmd), .four_wire_cable_i(four_wire),
    .speed_mag_o(spd), .cable_four_wire_o(cable));

  // ----
  // Access and check tasks
  // ----
  task automatic tally_and_finish();
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), rdata, e);
  endtask : rd

  // Bounded wait for a flag; running out ends the run
  task automatic wait_flag(input string nm, input int b, input logic v,
                           input int lim);
    int n;
    n = 0;
    #1;
    while (flg[b] !== v && n < lim)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    chk(nm, 16'(flg[b]), 16'(v));
    if (flg[b] !== v)
      tally_and_finish();
  endtask : wait_flag

  task automatic hold(input string nm, input int b, input logic v,
                      input int n);
    repeat (n)
    begin
      @(posedge core_clk_i);
      #1;
      chk(nm, 16'(flg[b]), 16'(v));
    end
  endtask : hold

  // Power-on edge; counts erase pulses seen after it
  task automatic pon(input int exp);
    int n;
    n = 0;
    @(posedge core_clk_i);
    power_on_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    power_on_i <= 1'b1;
    repeat (12)
    begin
      @(posedge core_clk_i);
      #1;
      n += (erase === 1'b1) ? 1 : 0;
    end
    chk("erase pulses", 16'(n), 16'(exp));
  endtask : pon

  task automatic brake(input logic [15:0] ms);
    int n;
    n = 0;
    wr(ADDR_BRK_DLY, ms);
    @(posedge core_clk_i);
    servo_off_i <= 1'b1;
    wait_flag("interlock", 0, 1'b1, 10);
    while (base_off !== 1'b1 && n < 5000)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    wait_flag("base off", 1, 1'b1, 0);
    chk("base off delay", 16'(n), ms * 16'(MS));
    @(posedge core_clk_i);
    servo_off_i <= 1'b0;
    wait_flag("interlock off", 0, 1'b0, 10);
  endtask : brake

  // ----
  // Main sequence
  // ----
  logic [15:0] rst_tab [8] = '{RST_MON2, RST_BRK_DLY, RST_ZSP_RNG,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  initial
  begin
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    chk("monitor", mon2, RST_MON2);
    for (int i = 0; i < 8; i++) rd(4'(i), rst_tab[i]);
    rd(4'hB, 16'h0000);
    wr(ADDR_MON2, 16'h000A);
    repeat (2) @(posedge core_clk_i);
    #1 chk("monitor", mon2, 16'h000A);
    wr(ADDR_BRK_DLY, 16'hFFFF);
    rd(ADDR_BRK_DLY, MAX_BRK_DLY);
    wr(ADDR_ZSP_RNG, 16'h2711);
    rd(ADDR_ZSP_RNG, MAX_ZSP_RNG);
    wr(ADDR_STATION, 16'h003F);
    rd(ADDR_STATION, 16'h001F);
    wait_flag("base on", 1, 1'b0, 20);
    wr(ADDR_IRQ_STAT, 16'h000F);
    brake(16'h0003);
    rd(ADDR_IRQ_STAT, 16'h0008);
    wait_flag("irq masked", 8, 1'b0, 3);
    wr(ADDR_IRQ_MASK, 16'h0008);
    wait_flag("irq", 8, 1'b1, 3);
    wr(ADDR_IRQ_MASK, 16'h0000);
    wait_flag("irq masked", 8, 1'b0, 3);
    wr(ADDR_IRQ_MASK, 16'h0008);
    wr(ADDR_IRQ_STAT, 16'h0008);
    wait_flag("irq cleared", 8, 1'b0, 3);
    rd(ADDR_IRQ_STAT, 16'h0000);
    brake(16'h0000);
    // Zero speed at a 100 r/min range, band edges 100 and 120
    wr(ADDR_ZSP_RNG, 16'h0064);
    speed_cmd <= 16'h00C8;
    wait_flag("zero speed", 2, 1'b0, 12);
    speed_cmd <= 16'h0078;
    hold("zero speed", 2, 1'b0, 8);
    speed_cmd <= 16'h0064;
    wait_flag("zero speed", 2, 1'b1, 12);
    speed_cmd <= 16'h0078;
    hold("zero speed", 2, 1'b1, 8);
    speed_cmd <= 16'h0079;
    wait_flag("zero speed", 2, 1'b0, 12);
    // Power-on latched settings
    wr(ADDR_ENC_OUT, 16'h1234);
    wr(ADDR_COMM_SEL, 16'h0ABC);
    wr(ADDR_STATION, 16'h0005);
    wr(ADDR_FUNC_C1, 16'h0011);
    wr(ADDR_LOG_CLR, 16'h0001);
    chk("pulse cfg", enc_cfg, 16'h0000);
    pon(1);
    rd(ADDR_LOG_CLR, 16'h0000);
    chk("pulse cfg", enc_cfg, 16'h1234);
    chk("comm cfg", comm_cfg, 16'h0ABC);
    wr(ADDR_ENC_OUT, 16'h5555);
    repeat (4) @(posedge core_clk_i);
    #1 chk("pulse cfg", enc_cfg, 16'h1234);
    wait_flag("alarm one", 4, 1'b1, 8);
    chk("alarm two", 16'(alm2), 16'h0000);
    rd(ADDR_STATUS, 16'h0005);
    @(posedge core_clk_i) power_dip_i <= 1'b1;
    wait_flag("restart", 6, 1'b1, 8);
    @(posedge core_clk_i) frame_i <= '{valid: 1'b1, station: 5'h05};
    wait_flag("accept", 7, 1'b1, 8);
    @(posedge core_clk_i) frame_i <= '0;
    wait_flag("accept", 7, 1'b0, 8);
    // A different axis on the shared link has its own station
    @(posedge core_clk_i) frame_i <= '{valid: 1'b1, station: 5'h06};
    hold("accept", 7, 1'b0, 8);
    @(posedge core_clk_i) frame_i <= '0;
    @(posedge core_clk_i) four_wire <= 1'b1;
    wr(ADDR_FUNC_C1, 16'h0000);
    pon(0);
    wait_flag("alarm two", 5, 1'b1, 8);
    wait_flag("restart", 6, 1'b0, 8);
    tally_and_finish();
  end

  initial
  begin
    repeat (30000) @(posedge core_clk_i);
    bad_count++;
    tally_and_finish();
  end
endmodule : test_servo_aux_config_bank
`default_nettype wire
